//--- hdl/t2a_pkg.sv
// t2a_pkg: constants and types for the auto-reload timer block
// assumes a 32-bit apb register bus and one system clock
package t2a_pkg;

    // register byte addresses
    localparam logic [7:0] ADDR_CONTROL = 8'h00;
    localparam logic [7:0] ADDR_CLK_SEL = 8'h04;
    localparam logic [7:0] ADDR_LOW_COUNT = 8'h08;
    localparam logic [7:0] ADDR_HIGH_COUNT = 8'h0c;
    localparam logic [7:0] ADDR_RELOAD_LOW = 8'h10;
    localparam logic [7:0] ADDR_RELOAD_HIGH = 8'h14;
    localparam logic [7:0] ADDR_IRQ_ENABLE = 8'h18;
    localparam logic [7:0] ADDR_STATUS = 8'h1c;
    localparam logic [7:0] ADDR_STATUS_CLEAR = 8'h20;
    localparam logic [7:0] ADDR_STATUS_ENABLE = 8'h24;

    // timer2_control fields
    localparam int CTL_HIGH_FLAG = 7;
    localparam int CTL_LOW_FLAG = 6;
    localparam int CTL_LOW_IRQ_EN = 5;
    localparam int CTL_SPLIT = 3;
    localparam int CTL_RUN = 2;
    localparam int CTL_EXT_SEL = 0;

    // clock_select_reg fields
    localparam int CKS_HIGH_SYSCLK = 5;
    localparam int CKS_LOW_SYSCLK = 4;

    // irq enable register field
    localparam int IE_TIMER2 = 5;

    // status, clear and enable layout
    localparam int ST_HIGH_OVF = 0;
    localparam int ST_LOW_OVF = 1;

    // clock dividers
    localparam logic [3:0] SYS_DIV_LAST = 4'hb;
    localparam logic [2:0] EXT_DIV_LAST = 3'h7;

    // reset value and count maximum
    localparam logic [7:0] BYTE_RESET = 8'h00;
    localparam logic [7:0] COUNT_MAX = 8'hff;

    typedef struct packed {
        logic high_flag;
        logic low_flag;
        logic low_irq_enable;
        logic split_mode_sel;
        logic t2_run;
        logic ext_clk_sel;
    } t2a_ctrl_type;

    localparam t2a_ctrl_type CTRL_RESET = '0;

endpackage

//--- hdl/t2a_byte_counter.sv
// t2a_byte_counter: one 8-bit counter byte with software write and reload
// assumes increment, load and write are single-cycle strobes on clk_sys
`timescale 1ns/1ps
`default_nettype none

module t2a_byte_counter
(
    // clock and reset
    input wire logic clk_sys,
    input wire logic reset_n,
    // control
    input wire logic inc,
    input wire logic load,
    input wire logic [7:0] load_value,
    input wire logic wr,
    input wire logic [7:0] wr_data,
    // state
    output logic [7:0] count,
    output logic wrap
);

    logic [7:0] count_reg;

    assign count = count_reg;
    assign wrap = inc && (count_reg == t2a_pkg::COUNT_MAX);

    // software write wins over counting in the same cycle
    always_ff @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
            count_reg <= t2a_pkg::BYTE_RESET;
        else if (wr)
            count_reg <= wr_data;
        else if (load)
            count_reg <= load_value;
        else if (inc)
            count_reg <= count_reg + 8'h01;
    end

endmodule // t2a_byte_counter

`default_nettype wire

//--- hdl/t2a_timer.sv
// t2a_timer: 16-bit or split dual 8-bit auto-reload timer with apb registers
// assumes ext_osc_clk is asynchronous and slower than half of clk_sys
`timescale 1ns/1ps
`default_nettype none

// Operation
// - count is two software read/write bytes forming one 16-bit value
// - split_mode_sel bit 3 picks one 16-bit or two 8-bit counters
// - tick sources: system clock, system clock /12, external oscillator /8
// - external oscillator passes two flip-flops before its /8 divider
// - 16-bit rollover from 0xffff reloads both bytes and sets high flag
// - timer2_irq_enable requests interrupt on every full 16-bit overflow while status enable bit 0 is set
// - with low_irq_enable and status enable bit 1 also, low byte rollover requests interrupt too
// - split mode: each byte reloads from its own reload register
// - split mode: t2_run gates high byte only; low byte always counts
// - per-byte sysclk select bit, else ext_clk_sel picks /12 or /8
// - split mode: each byte rollover sets its own overflow flag
// - split mode: high overflow interrupts with status enable bit 0; low too with low_irq_enable and bit 1
// - flags are never cleared by hardware, only by software writes
module t2a_timer
(
    // clock and reset
    input wire logic clk_sys,
    input wire logic reset_n,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // external oscillator pin
    input wire logic ext_osc_clk,
    // interrupt
    output logic irq
);

    t2a_pkg::t2a_ctrl_type ctrl_reg;
    logic high_clk_sysclk_sel_reg;
    logic low_clk_sysclk_sel_reg;
    logic [7:0] reload_low_reg;
    logic [7:0] reload_high_reg;
    logic timer2_irq_enable_reg;
    logic [1:0] status_reg;
    logic [1:0] status_en_reg;
    logic [31:0] prdata_reg;
    logic pready_reg;
    logic pslverr_reg;
    logic irq_reg;

    logic [3:0] sys_div_reg;
    logic ext_sync1_reg;
    logic ext_sync2_reg;
    logic ext_prev_reg;
    logic [2:0] ext_div_reg;
    logic tick_sys12;
    logic tick_ext8;
    logic tick_low;
    logic tick_high;

    logic [7:0] t2_low_count;
    logic [7:0] t2_high_count;
    logic low_inc;
    logic high_inc;
    logic low_load;
    logic high_load;
    logic low_wrap;
    logic high_wrap;
    logic high_ovf_event;
    logic low_ovf_event;

    logic access;
    logic wr_en;
    logic addr_ok;
    logic [31:0] rd_value;
    logic wr_control;
    logic wr_clk_sel;
    logic wr_low_count;
    logic wr_high_count;
    logic wr_status_clear;
    logic irq_high_src;
    logic irq_low_src;

    // apb decode
    assign access = psel && penable && pready_reg;
    assign wr_en = access && pwrite;

    // one strobe per register, only at the access edge so a stalled setup never writes
    assign wr_control = wr_en && (paddr == t2a_pkg::ADDR_CONTROL);
    assign wr_clk_sel = wr_en && (paddr == t2a_pkg::ADDR_CLK_SEL);
    assign wr_low_count = wr_en && (paddr == t2a_pkg::ADDR_LOW_COUNT);
    assign wr_high_count = wr_en && (paddr == t2a_pkg::ADDR_HIGH_COUNT);
    assign wr_status_clear = wr_en && (paddr == t2a_pkg::ADDR_STATUS_CLEAR);

    always_comb
    begin
        addr_ok = 1'b1;
        rd_value = 32'h0000_0000;
        unique case (paddr)
            t2a_pkg::ADDR_CONTROL:
            begin
                rd_value[t2a_pkg::CTL_HIGH_FLAG] = ctrl_reg.high_flag;
                rd_value[t2a_pkg::CTL_LOW_FLAG] = ctrl_reg.low_flag;
                rd_value[t2a_pkg::CTL_LOW_IRQ_EN] = ctrl_reg.low_irq_enable;
                rd_value[t2a_pkg::CTL_SPLIT] = ctrl_reg.split_mode_sel;
                rd_value[t2a_pkg::CTL_RUN] = ctrl_reg.t2_run;
                rd_value[t2a_pkg::CTL_EXT_SEL] = ctrl_reg.ext_clk_sel;
            end
            t2a_pkg::ADDR_CLK_SEL:
            begin
                rd_value[t2a_pkg::CKS_HIGH_SYSCLK] = high_clk_sysclk_sel_reg;
                rd_value[t2a_pkg::CKS_LOW_SYSCLK] = low_clk_sysclk_sel_reg;
            end
            t2a_pkg::ADDR_LOW_COUNT:
                rd_value[7:0] = t2_low_count;
            t2a_pkg::ADDR_HIGH_COUNT:
                rd_value[7:0] = t2_high_count;
            t2a_pkg::ADDR_RELOAD_LOW:
                rd_value[7:0] = reload_low_reg;
            t2a_pkg::ADDR_RELOAD_HIGH:
                rd_value[7:0] = reload_high_reg;
            t2a_pkg::ADDR_IRQ_ENABLE:
                rd_value[t2a_pkg::IE_TIMER2] = timer2_irq_enable_reg;
            t2a_pkg::ADDR_STATUS:
                rd_value[1:0] = status_reg;
            t2a_pkg::ADDR_STATUS_CLEAR:
                rd_value = 32'h0000_0000;
            t2a_pkg::ADDR_STATUS_ENABLE:
                rd_value[1:0] = status_en_reg;
            default:
                addr_ok = 1'b0;
        endcase
    end

    // no wait state: ready follows the setup cycle
    always_ff @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
        begin
            pready_reg <= 1'b0;
            prdata_reg <= 32'h0000_0000;
            pslverr_reg <= 1'b0;
        end
        else
        begin
            pready_reg <= psel && !penable;
            if (psel && !penable)
            begin
                prdata_reg <= pwrite ? 32'h0000_0000 : rd_value;
                pslverr_reg <= !addr_ok;
            end
            else
                pslverr_reg <= 1'b0;
        end
    end

    assign prdata = prdata_reg;
    assign pready = pready_reg;
    assign pslverr = pslverr_reg;

    // control and configuration registers
    always_ff @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
        begin
            ctrl_reg <= t2a_pkg::CTRL_RESET;
            high_clk_sysclk_sel_reg <= 1'b0;
            low_clk_sysclk_sel_reg <= 1'b0;
            reload_low_reg <= t2a_pkg::BYTE_RESET;
            reload_high_reg <= t2a_pkg::BYTE_RESET;
            timer2_irq_enable_reg <= 1'b0;
            status_en_reg <= 2'h0;
        end
        else
        begin
            if (wr_control)
            begin
                ctrl_reg.low_irq_enable <= pwdata[t2a_pkg::CTL_LOW_IRQ_EN];
                ctrl_reg.split_mode_sel <= pwdata[t2a_pkg::CTL_SPLIT];
                ctrl_reg.t2_run <= pwdata[t2a_pkg::CTL_RUN];
                ctrl_reg.ext_clk_sel <= pwdata[t2a_pkg::CTL_EXT_SEL];
            end
            // flags: only software clears; a same-cycle overflow still sets
            if (wr_control)
            begin
                ctrl_reg.high_flag <= pwdata[t2a_pkg::CTL_HIGH_FLAG] | high_ovf_event;
                ctrl_reg.low_flag <= pwdata[t2a_pkg::CTL_LOW_FLAG] | low_ovf_event;
            end
            else
            begin
                ctrl_reg.high_flag <= ctrl_reg.high_flag | high_ovf_event;
                ctrl_reg.low_flag <= ctrl_reg.low_flag | low_ovf_event;
            end
            if (wr_clk_sel)
            begin
                high_clk_sysclk_sel_reg <= pwdata[t2a_pkg::CKS_HIGH_SYSCLK];
                low_clk_sysclk_sel_reg <= pwdata[t2a_pkg::CKS_LOW_SYSCLK];
            end
            if (wr_en && paddr == t2a_pkg::ADDR_RELOAD_LOW)
                reload_low_reg <= pwdata[7:0];
            if (wr_en && paddr == t2a_pkg::ADDR_RELOAD_HIGH)
                reload_high_reg <= pwdata[7:0];
            if (wr_en && paddr == t2a_pkg::ADDR_IRQ_ENABLE)
                timer2_irq_enable_reg <= pwdata[t2a_pkg::IE_TIMER2];
            if (wr_en && paddr == t2a_pkg::ADDR_STATUS_ENABLE)
                status_en_reg <= pwdata[1:0];
        end
    end

    // system clock divided by 12
    // free-running: the first tick after a start lands anywhere within 12 cycles
    always_ff @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
            sys_div_reg <= 4'h0;
        else if (sys_div_reg == t2a_pkg::SYS_DIV_LAST)
            sys_div_reg <= 4'h0;
        else
            sys_div_reg <= sys_div_reg + 4'h1;
    end

    assign tick_sys12 = (sys_div_reg == t2a_pkg::SYS_DIV_LAST);

    // external oscillator: synchronise first, only then edge-detect
    always_ff @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
        begin
            ext_sync1_reg <= 1'b0;
            ext_sync2_reg <= 1'b0;
            ext_prev_reg <= 1'b0;
        end
        else
        begin
            ext_sync1_reg <= ext_osc_clk;
            ext_sync2_reg <= ext_sync1_reg;
            ext_prev_reg <= ext_sync2_reg;
        end
    end

    // divide synchronised rising edges by 8
    // a stray edge right after reset only shifts the phase of the divider
    always_ff @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
            ext_div_reg <= 3'h0;
        else if (ext_sync2_reg && !ext_prev_reg)
            ext_div_reg <= ext_div_reg + 3'h1;
    end

    assign tick_ext8 = ext_sync2_reg && !ext_prev_reg && (ext_div_reg == t2a_pkg::EXT_DIV_LAST);

    // per-byte source select; 16-bit mode uses the low byte's select
    assign tick_low = low_clk_sysclk_sel_reg ? 1'b1 :
        (ctrl_reg.ext_clk_sel ? tick_ext8 : tick_sys12);
    assign tick_high = high_clk_sysclk_sel_reg ? 1'b1 :
        (ctrl_reg.ext_clk_sel ? tick_ext8 : tick_sys12);

    // count enables and reloads per mode
    always_comb
    begin
        if (ctrl_reg.split_mode_sel)
        begin
            low_inc = tick_low;
            high_inc = ctrl_reg.t2_run && tick_high;
            low_load = low_wrap;
            high_load = high_wrap;
            high_ovf_event = high_wrap;
            low_ovf_event = low_wrap;
        end
        else
        begin
            low_inc = ctrl_reg.t2_run && tick_low;
            high_inc = low_wrap;
            low_load = high_wrap;
            high_load = high_wrap;
            high_ovf_event = high_wrap;
            low_ovf_event = low_wrap;
        end
    end

    t2a_byte_counter u_low
    (
        .clk_sys(clk_sys),
        .reset_n(reset_n),
        .inc(low_inc),
        .load(low_load),
        .load_value(reload_low_reg),
        .wr(wr_low_count),
        .wr_data(pwdata[7:0]),
        .count(t2_low_count),
        .wrap(low_wrap)
    );

    t2a_byte_counter u_high
    (
        .clk_sys(clk_sys),
        .reset_n(reset_n),
        .inc(high_inc),
        .load(high_load),
        .load_value(reload_high_reg),
        .wr(wr_high_count),
        .wr_data(pwdata[7:0]),
        .count(t2_high_count),
        .wrap(high_wrap)
    );

    // sticky status; a set in the clearing cycle survives
    always_ff @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
            status_reg <= 2'h0;
        else if (wr_status_clear)
            status_reg <= (status_reg & ~pwdata[1:0]) | {low_ovf_event, high_ovf_event};
        else
            status_reg <= status_reg | {low_ovf_event, high_ovf_event};
    end

    // a source needs its control flag and its enabled status bit both set
    assign irq_high_src = ctrl_reg.high_flag && status_en_reg[t2a_pkg::ST_HIGH_OVF] &&
        status_reg[t2a_pkg::ST_HIGH_OVF];
    assign irq_low_src = ctrl_reg.low_irq_enable && ctrl_reg.low_flag &&
        status_en_reg[t2a_pkg::ST_LOW_OVF] && status_reg[t2a_pkg::ST_LOW_OVF];

    // interrupt level: the timer flags, further gated by the status enables
    always_ff @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
            irq_reg <= 1'b0;
        else
            irq_reg <= timer2_irq_enable_reg && (irq_high_src || irq_low_src);
    end

    assign irq = irq_reg;

endmodule // t2a_timer

`default_nettype wire

//--- sim/t2a_timer_sva.sv
// t2a_timer_sva: port checks of the timer apb slave and its irq
// assumes one clk_sys domain and a well behaved apb master
`timescale 1ns/1ps
`default_nettype none

module t2a_timer_chk
(
    // clock and reset
    input wire logic clk_sys,
    input wire logic reset_n,
    // apb
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // pins
    input wire logic ext_osc_clk,
    input wire logic irq
);
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!reset_n);

    property p_ready_next;
        psel && !penable |=> pready;
    endproperty
    a_ready_next: assert property (p_ready_next)
        else $error("no pready after setup");
    property p_ready_pulse;
        pready |=> !pready;
    endproperty
    a_ready_pulse: assert property (p_ready_pulse)
        else $error("pready longer than one cycle");
    property p_ready_access;
        pready |-> psel && penable;
    endproperty
    a_ready_access: assert property (p_ready_access)
        else $error("pready outside access phase");
    property p_err_unmapped;
        pready && paddr > 8'h24 |-> pslverr;
    endproperty
    a_err_unmapped: assert property (p_err_unmapped)
        else $error("unmapped access without error");
    property p_err_mapped;
        pready && paddr <= 8'h24 && paddr[1:0] == 2'b00 |-> !pslverr;
    endproperty
    a_err_mapped: assert property (p_err_mapped)
        else $error("error on mapped register");
    property p_ctrl_reserved;
        pready && !pwrite && paddr == 8'h00 |-> prdata[31:8] == 24'h0 && !prdata[4] && !prdata[1];
    endproperty
    a_ctrl_reserved: assert property (p_ctrl_reserved)
        else $error("reserved control bits not zero");
    property p_clear_reads_zero;
        pready && !pwrite && paddr == 8'h20 |-> prdata == 32'h0;
    endproperty
    a_clear_reads_zero: assert property (p_clear_reads_zero)
        else $error("clear register reads nonzero");
    // hardware never drops a request by itself, only a write can
    property p_irq_fall;
        $fell(irq) |-> $past(pwrite && pready) || $past(pwrite && pready, 2);
    endproperty
    a_irq_fall: assert property (p_irq_fall)
        else $error("irq dropped without a write");
endmodule // t2a_timer_chk

bind t2a_timer t2a_timer_chk i_chk (.clk_sys(clk_sys), .reset_n(reset_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .ext_osc_clk(ext_osc_clk), .irq(irq));

`default_nettype wire

//--- sim/tb.sv
// tb: self-checking bench for the auto-reload timer over apb
// assumes the checker is bound from its own file
`timescale 1ns/1ps
`default_nettype none

module tb;
    logic clk_sys, reset_n, psel, penable, pwrite, pready, pslverr, irq, err;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [1:0] ext_div;
    logic ext_osc_clk;
    int mismatches, n_compared;

    t2a_timer i_dut (.clk_sys(clk_sys), .reset_n(reset_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .ext_osc_clk(ext_osc_clk), .irq(irq));

    initial
    begin
        clk_sys = 1'b0;
        forever #10 clk_sys = ~clk_sys;
    end
    // oscillator at clk_sys/4, below the clk_sys/2 limit
    always @(posedge clk_sys)
        ext_div <= ext_div + 2'b01;
    assign ext_osc_clk = ext_div[1];

    task summarize;
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            mismatches++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        @(posedge clk_sys);
        while (pready !== 1'b1)
            @(posedge clk_sys);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task wr(input logic [7:0] a, input logic [31:0] d);
        xfer(1'b1, a, d);
    endtask
    task rchk(input logic [7:0] a, input logic [31:0] e);
        xfer(1'b0, a, 32'h0);
        chk(rd, e);
    endtask
    task rng(input logic [7:0] lo, input logic [7:0] hi);
        chk({31'h0, rd[7:0] >= lo && rd[7:0] <= hi}, 32'h1);
    endtask
    task wirq;
        int i;
        for (i = 0; i < 300 && irq !== 1'b1; i++)
            @(posedge clk_sys);
        chk({31'h0, irq}, 32'h1);
    endtask
    // mask through status enable, unmask, then clear for real
    task clr;
        wr(8'h24, 32'h0);
        repeat (2) @(posedge clk_sys);
        chk({31'h0, irq}, 32'h0);
        wr(8'h24, 32'h3);
        repeat (2) @(posedge clk_sys);
        chk({31'h0, irq}, 32'h1);
        wr(8'h20, 32'h3);
        wr(8'h00, 32'h0);
        repeat (2) @(posedge clk_sys);
        chk({31'h0, irq}, 32'h0);
    endtask

    task t_regs;
        for (int a = 0; a <= 36; a += 4)
            rchk(a[7:0], 32'h0);
        wr(8'h08, 32'ha5);
        wr(8'h0c, 32'h5a);
        wr(8'h10, 32'h34);
        wr(8'h14, 32'h12);
        rchk(8'h08, 32'ha5);
        rchk(8'h0c, 32'h5a);
        rchk(8'h10, 32'h34);
        rchk(8'h14, 32'h12);
        wr(8'h28, 32'hff);
        chk({31'h0, err}, 32'h1);
        rchk(8'h28, 32'h0);
        wr(8'h00, 32'h3f);
        rchk(8'h00, 32'h2d);
        wr(8'h00, 32'h0);
        $display("regs done");
    endtask
    // 16-bit mode wrap: full overflow, or low byte only
    task t16(input logic low_only);
        wr(8'h04, 32'h10);
        wr(8'h08, 32'hfe);
        wr(8'h0c, low_only ? 32'h00 : 32'hff);
        wr(8'h18, 32'h20);
        wr(8'h24, 32'h3);
        wr(8'h00, low_only ? 32'h24 : 32'h04);
        wirq;
        rchk(8'h00, low_only ? 32'h64 : 32'hc4);
        wr(8'h00, low_only ? 32'h60 : 32'hc0);
        rchk(8'h0c, low_only ? 32'h01 : 32'h12);
        xfer(1'b0, 8'h08, 32'h0);
        rng(low_only ? 8'h00 : 8'h35, low_only ? 8'h30 : 8'h60);
        rchk(8'h08, rd);
        if (low_only)
            rchk(8'h00, 32'h60);
        clr;
        $display("wrap16 done");
    endtask
    task t_split;
        wr(8'h04, 32'h30);
        wr(8'h10, 32'hf0);
        wr(8'h14, 32'h77);
        wr(8'h08, 32'hfe);
        wr(8'h0c, 32'h05);
        wr(8'h00, 32'h28);
        wirq;
        rchk(8'h0c, 32'h05);
        xfer(1'b0, 8'h08, 32'h0);
        rng(8'hf0, 8'hff);
        rchk(8'h00, 32'h68);
        wr(8'h20, 32'h3);
        wr(8'h00, 32'h08);
        repeat (2) @(posedge clk_sys);
        chk({31'h0, irq}, 32'h0);
        wr(8'h0c, 32'hff);
        wr(8'h00, 32'h0c);
        wirq;
        xfer(1'b0, 8'h00, 32'h0);
        chk({31'h0, rd[7]}, 32'h1);
        xfer(1'b0, 8'h1c, 32'h0);
        chk({31'h0, rd[0]}, 32'h1);
        wr(8'h00, 32'hc8);
        xfer(1'b0, 8'h0c, 32'h0);
        rng(8'h77, 8'ha0);
        clr;
        $display("split done");
    endtask
    // tick rates: /12 over 120 cycles, ext/8 over 320 cycles
    task t_clk;
        wr(8'h04, 32'h0);
        for (int e = 0; e < 2; e++)
        begin
            wr(8'h08, 32'h0);
            wr(8'h00, 32'h04 | e);
            repeat (e ? 320 : 120) @(posedge clk_sys);
            wr(8'h00, 32'h0);
            xfer(1'b0, 8'h08, 32'h0);
            rng(8'h09, 8'h0b);
        end
        $display("clock sources done");
    endtask

    initial
    begin
        reset_n = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        ext_div = 2'b00;
        mismatches = 0;
        n_compared = 0;
        repeat (16) @(posedge clk_sys);
        reset_n <= 1'b1;
        t_regs;
        t16(1'b0);
        t16(1'b1);
        t_split;
        t_clk;
        summarize;
    end
    // whole run is under a thousand cycles
    initial
    begin
        #200000;
        mismatches++;
        summarize;
    end
endmodule // tb

`default_nettype wire
